// [hw/ccsp_consts.vh]
// Constants for the clock count, status and pin 0 register group
`ifndef CCSP_CONSTS_VH
`define CCSP_CONSTS_VH

// Register offsets on the internal 8-bit register port
`define CCSP_ADDR_FREQ_COUNT   8'h1b
`define CCSP_ADDR_LINK_STATUS  8'h1c
`define CCSP_ADDR_PIN0_CONFIG  8'h1d

// Status bit positions
`define CCSP_STS_TX_DUAL       5
`define CCSP_STS_RX_DUAL       4
`define CCSP_STS_AUDIO_LOCK    3
`define CCSP_STS_SIG_DETECT    1
`define CCSP_STS_LINK_LOCK     0

// Pin 0 configuration field positions
`define CCSP_PIN0_REV_HI       7
`define CCSP_PIN0_REV_LO       4
`define CCSP_PIN0_LEVEL        3
`define CCSP_PIN0_REMOTE       2
`define CCSP_PIN0_DIR          1
`define CCSP_PIN0_EN           0

// Reset values
`define CCSP_FREQ_RESET        8'h00
`define CCSP_PIN0_CFG_RESET    4'h0
// Arbitrary revision value, not a real part code
`define CCSP_REVISION_VALUE    4'ha

// Timing: oscillator period and system clock period in picoseconds
`define CCSP_OSC_PERIOD_PS     50000
`define CCSP_SYS_PERIOD_PS     4000
// Whole system cycles per oscillator period (least time, rounded up)
`define CCSP_OSC_CYCLES        ((`CCSP_OSC_PERIOD_PS + `CCSP_SYS_PERIOD_PS - 1) / `CCSP_SYS_PERIOD_PS)
`define CCSP_COUNT_MAX         8'hff

`endif

// [hw/ccsp_sync3.v]
// Three-stage input synchroniser with agreement check on the last two stages
`default_nettype none

module ccsp_sync3
(
    input  wire  i_clk_sys,
    input  wire  i_rstn,
    input  wire  i_async,
    output reg   o_level
);

    reg  [2:0]  stage_r;

    //--------------------------------------------------------------
    // Synchroniser chain
    //--------------------------------------------------------------
    // Stage 0 feeds only stage 1; level changes once stages 1 and 2 agree
    always @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            stage_r <= 3'h0;
            o_level <= 1'b0;
        end
        else
        begin
            stage_r <= {stage_r[1:0], i_async};
            if (stage_r[1] == stage_r[2])
                o_level <= stage_r[2];
        end
    end

endmodule // ccsp_sync3

`default_nettype wire

// [hw/ccsp_regs.v]
// Clock frequency counter, link status and pin 0 configuration registers
`default_nettype none
`include "ccsp_consts.vh"

module ccsp_regs
(
    input  wire        i_clk_sys,
    input  wire        i_rstn,
    // Internal register port
    input  wire        i_reg_wr,
    input  wire        i_reg_rd,
    input  wire [7:0]  i_reg_addr,
    input  wire [7:0]  i_reg_wdata,
    output reg  [7:0]  o_reg_rdata,
    output reg         o_reg_rvalid,
    // Pixel clock, sampled as a pin
    input  wire        i_pixel_clk,
    // Status sources from the link logic
    input  wire        i_transmit_dual_link,
    input  wire        i_receive_dual_link,
    input  wire        i_audio_pll_locked,
    input  wire        i_serial_detect,
    input  wire        i_lock_ch0,
    input  wire        i_lock_ch1,
    // Pin 0 control
    input  wire        i_second_port_select,
    input  wire        i_pin0_functional,
    input  wire        i_pin0_remote_level,
    input  wire        i_pin0_in,
    input  wire        i_second_port_pin0_in,
    output reg         o_pin0_out,
    output reg         o_pin0_oe_n,
    output reg         o_second_port_pin0_out,
    output reg         o_second_port_pin0_oe_n,
    output reg         o_pin0_sampled,
    output reg         o_measure_busy
);

    localparam integer OSC_CYC_I = `CCSP_OSC_CYCLES;
    localparam [7:0]   OSC_CYC   = OSC_CYC_I[7:0];

    wire        pix_s;
    wire [1:0]  pad_in = {i_second_port_pin0_in, i_pin0_in};
    wire [1:0]  pad_s;
    genvar      gi;
    reg         pix_prev_r;
    reg  [7:0]  count_r;
    reg  [7:0]  result_r;
    reg  [7:0]  osc_left_r;
    reg  [7:0]  tick_div_r;
    reg  [3:0]  pin_cfg_r;
    reg  [7:0]  status_r;
    reg         drv_out_nxt;
    reg         drv_oe_n_nxt;

    // Address match used by both the write and read paths
    function sel;
        input [7:0] addr;
        input [7:0] target;
        begin
            sel = (addr == target);
        end
    endfunction

    //--------------------------------------------------------------
    // Pixel clock edge detection
    //--------------------------------------------------------------
    // Pixel clock is sampled; only clocks well below half the system rate count exactly
    ccsp_sync3 ccsp_sync3_inst
    (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_async   (i_pixel_clk),
        .o_level   (pix_s)
    );

    // Pad inputs are asynchronous, so each passes its own filter before the mux
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_pad_sync
            ccsp_sync3 ccsp_sync3_inst
            (
                .i_clk_sys (i_clk_sys),
                .i_rstn    (i_rstn),
                .i_async   (pad_in[gi]),
                .o_level   (pad_s[gi])
            );
        end
    endgenerate

    wire pix_rise = pix_s & ~pix_prev_r;
    wire fc_wr    = i_reg_wr & sel(i_reg_addr, `CCSP_ADDR_FREQ_COUNT);
    wire osc_tick = (tick_div_r == OSC_CYC - 8'h01);

    //--------------------------------------------------------------
    // Frequency measurement
    //--------------------------------------------------------------
    // Interval counts oscillator periods; edge count saturates
    always @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pix_prev_r     <= 1'b0;
            count_r        <= `CCSP_FREQ_RESET;
            result_r       <= `CCSP_FREQ_RESET;
            osc_left_r     <= 8'h00;
            tick_div_r     <= 8'h00;
            o_measure_busy <= 1'b0;
        end
        else
        begin
            pix_prev_r <= pix_s;
            if (fc_wr)
            begin
                // New write always restarts, even mid-interval
                count_r        <= 8'h00;
                osc_left_r     <= i_reg_wdata;
                tick_div_r     <= 8'h00;
                o_measure_busy <= (i_reg_wdata != 8'h00);
                if (i_reg_wdata == 8'h00)
                    result_r <= 8'h00;                        // Empty interval sees no edges
            end
            else if (o_measure_busy)
            begin
                tick_div_r <= osc_tick ? 8'h00 : tick_div_r + 8'h01;
                if (pix_rise && count_r != `CCSP_COUNT_MAX)
                    count_r <= count_r + 8'h01;
                if (osc_tick)
                begin
                    osc_left_r <= osc_left_r - 8'h01;
                    if (osc_left_r == 8'h01)
                    begin
                        o_measure_busy <= 1'b0;
                        // Include an edge landing on the final cycle, still saturating
                        result_r <= (pix_rise && count_r != `CCSP_COUNT_MAX)
                                    ? count_r + 8'h01 : count_r;
                    end
                end
            end
        end
    end

    //--------------------------------------------------------------
    // Status capture
    //--------------------------------------------------------------
    // Sources are on the system clock; registered for a stable read value
    always @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            status_r <= 8'h00;
        else
        begin
            status_r                         <= 8'h00;
            status_r[`CCSP_STS_TX_DUAL]      <= i_transmit_dual_link;
            status_r[`CCSP_STS_RX_DUAL]      <= i_receive_dual_link;
            status_r[`CCSP_STS_AUDIO_LOCK]   <= i_audio_pll_locked;
            status_r[`CCSP_STS_SIG_DETECT]   <= i_serial_detect;
            status_r[`CCSP_STS_LINK_LOCK]    <= i_lock_ch0 &
                (~i_receive_dual_link | i_lock_ch1);
        end
    end

    //--------------------------------------------------------------
    // Pin 0 configuration register
    //--------------------------------------------------------------
    always @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            pin_cfg_r <= `CCSP_PIN0_CFG_RESET;
        else if (i_reg_wr && sel(i_reg_addr, `CCSP_ADDR_PIN0_CONFIG))
            pin_cfg_r <= i_reg_wdata[`CCSP_PIN0_LEVEL:`CCSP_PIN0_EN];
    end

    //--------------------------------------------------------------
    // Pin drive decode
    //--------------------------------------------------------------
    // Remote control overrides the direction pair
    always @*
    begin
        drv_out_nxt  = 1'b0;
        drv_oe_n_nxt = 1'b1;
        if (pin_cfg_r[`CCSP_PIN0_REMOTE])
        begin
            drv_out_nxt  = i_pin0_remote_level;
            drv_oe_n_nxt = 1'b0;
        end
        else
        begin
            case ({pin_cfg_r[`CCSP_PIN0_DIR], pin_cfg_r[`CCSP_PIN0_EN]})
                2'b00:
                begin
                    drv_out_nxt  = i_pin0_functional;
                    drv_oe_n_nxt = 1'b0;
                end
                2'b01:
                begin
                    drv_out_nxt  = pin_cfg_r[`CCSP_PIN0_LEVEL];
                    drv_oe_n_nxt = 1'b0;
                end
                2'b10:
                    drv_oe_n_nxt = 1'b1;
                2'b11:
                    drv_oe_n_nxt = 1'b1;
                default:
                    drv_oe_n_nxt = 1'b1;
            endcase
        end
    end

    // Unselected pin stays released so only one port is steered
    always @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_pin0_out              <= 1'b0;
            o_pin0_oe_n             <= 1'b1;
            o_second_port_pin0_out  <= 1'b0;
            o_second_port_pin0_oe_n <= 1'b1;
            o_pin0_sampled          <= 1'b0;
        end
        else
        begin
            if (i_second_port_select)
            begin
                o_second_port_pin0_out  <= drv_out_nxt;
                o_second_port_pin0_oe_n <= drv_oe_n_nxt;
                o_pin0_out              <= 1'b0;
                o_pin0_oe_n             <= 1'b1;
                o_pin0_sampled          <= pad_s[1];
            end
            else
            begin
                o_pin0_out              <= drv_out_nxt;
                o_pin0_oe_n             <= drv_oe_n_nxt;
                o_second_port_pin0_out  <= 1'b0;
                o_second_port_pin0_oe_n <= 1'b1;
                o_pin0_sampled          <= pad_s[0];
            end
        end
    end

    //--------------------------------------------------------------
    // Read path
    //--------------------------------------------------------------
    // One cycle read latency; unmapped offsets read zero
    always @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_reg_rdata  <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end
        else
        begin
            o_reg_rvalid <= i_reg_rd;
            if (!i_reg_rd)
                o_reg_rdata <= o_reg_rdata;
            else if (sel(i_reg_addr, `CCSP_ADDR_FREQ_COUNT))
                o_reg_rdata <= result_r;
            else if (sel(i_reg_addr, `CCSP_ADDR_LINK_STATUS))
                o_reg_rdata <= status_r;
            else if (sel(i_reg_addr, `CCSP_ADDR_PIN0_CONFIG))
                o_reg_rdata <= {`CCSP_REVISION_VALUE, pin_cfg_r};
            else
                o_reg_rdata <= 8'h00;
        end
    end

endmodule // ccsp_regs

`default_nettype wire

// [tb/ccsp_regs_monitor.sv]
// Checker for the clock count, status and pin 0 register group
`default_nettype none

module ccsp_regs_monitor
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_rstn,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic [7:0] o_reg_rdata,
    input  wire logic       o_reg_rvalid,
    input  wire logic       i_second_port_select,
    input  wire logic       o_pin0_oe_n,
    input  wire logic       o_second_port_pin0_oe_n,
    input  wire logic       o_measure_busy
);
    // ----------------------------------------
    // Properties, all in the system clock domain
    // ----------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    // A one-tick measurement, then a quiet spell as long as one oscillator period
    sequence s_go_one;
        i_reg_wr && i_reg_addr == 8'h1b && i_reg_wdata == 8'h01;
    endsequence
    sequence s_quiet_13;
        (!i_reg_wr)[*8] ##1 (!i_reg_wr)[*5];
    endsequence

    AST_RVALID_NEXT: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read not answered next cycle");
    AST_RVALID_ONLY: assert property (!i_reg_rd |=> !o_reg_rvalid)
        else $error("read valid without a read");
    AST_REVISION: assert property (i_reg_rd && i_reg_addr == 8'h1d |=> o_reg_rdata[7:4] == 4'ha)
        else $error("revision field wrong");
    AST_STS_RSVD: assert property (i_reg_rd && i_reg_addr == 8'h1c |=> o_reg_rdata[7:6] == 2'b00 && !o_reg_rdata[2])
        else $error("reserved status bits set");
    AST_START: assert property (i_reg_wr && i_reg_addr == 8'h1b && i_reg_wdata != 8'h00 |=> o_measure_busy)
        else $error("measurement not started");
    AST_ZERO: assert property (i_reg_wr && i_reg_addr == 8'h1b && i_reg_wdata == 8'h00 |=> !o_measure_busy)
        else $error("empty interval left busy");
    AST_DURATION: assert property (s_go_one ##1 s_quiet_13 |-> o_measure_busy ##1 !o_measure_busy)
        else $error("interval length wrong");
    AST_ROSE_CAUSE: assert property ($rose(o_measure_busy) |-> $past(i_reg_wr) && $past(i_reg_addr) == 8'h1b)
        else $error("busy rose without a write");
    AST_SECOND_FREE: assert property (!i_second_port_select |=> o_second_port_pin0_oe_n)
        else $error("unselected second pin driven");
    AST_PRIMARY_FREE: assert property (i_second_port_select |=> o_pin0_oe_n)
        else $error("unselected primary pin driven");
endmodule // ccsp_regs_monitor

bind ccsp_regs ccsp_regs_monitor ccsp_regs_monitor_inst (.i_clk_sys, .i_rstn, .i_reg_wr,
    .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .i_second_port_select,
    .o_pin0_oe_n, .o_second_port_pin0_oe_n, .o_measure_busy);

`default_nettype wire

// [tb/ccsp_regs_tb.sv]
// Self-checking bench for the clock count, status and pin 0 registers
`default_nettype none
`include "ccsp_consts.vh"

module ccsp_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Stimulus, design and shared tasks
    // ----------------------------------------
    logic       clk = 0, rstn = 0, wr = 0, rd = 0, pix = 0, sel = 0;
    logic       fun = 1, rem = 1, pin = 0, pin2 = 0, po, poe, so, soe, smp, busy, rv;
    logic [7:0] addr = 0, wd = 0, rdata;
    logic [5:0] sts = 0;
    int         err_count = 0, total_checks = 0, cyc = 0, n;

    ccsp_regs ccsp_regs_inst (.i_clk_sys(clk), .i_rstn(rstn), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdata), .o_reg_rvalid(rv),
        .i_pixel_clk(pix), .i_transmit_dual_link(sts[5]), .i_receive_dual_link(sts[4]),
        .i_audio_pll_locked(sts[3]), .i_serial_detect(sts[2]), .i_lock_ch0(sts[0]),
        .i_lock_ch1(sts[1]), .i_second_port_select(sel), .i_pin0_functional(fun),
        .i_pin0_remote_level(rem), .i_pin0_in(pin), .i_second_port_pin0_in(pin2),
        .o_pin0_out(po), .o_pin0_oe_n(poe), .o_second_port_pin0_out(so),
        .o_second_port_pin0_oe_n(soe), .o_pin0_sampled(smp), .o_measure_busy(busy));

    always #2 clk = ~clk;

    // Hang guard: the whole run needs well under 4000 cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            err_count++;
            close_out();
        end
    end

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = 1;
        addr = a;
        wd = d;
        @(negedge clk);
        wr = 0;
    endtask

    // Valid stands for one cycle only, so look in that cycle; data holds until the next read
    task rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        rd = 1;
        addr = a;
        @(negedge clk);
        rd = 0;
        chk({rv, rdata}, {1'b1, exp});
    endtask

    task wait_idle();
        n = 0;
        while (busy === 1'b1 && n < 4000)
        begin
            @(negedge clk);
            n++;
        end
    endtask

    // Slow enough that the pin filter keeps every edge
    task pix_edges(input int k);
        repeat (k)
        begin
            pix = 1;
            repeat (2) @(negedge clk);
            pix = 0;
            repeat (2) @(negedge clk);
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset();
        rd_reg(8'h1b, 8'h00);
        rd_reg(8'h1d, {`CCSP_REVISION_VALUE, 4'h0});
        chk({poe, po}, 2'b01);
        rd_reg(8'h40, 8'h00);
        $display("done reset");
    endtask

    task t_status();
        for (int v = 0; v < 64; v++)
        begin
            sts = v[5:0];
            repeat (2) @(negedge clk);
            rd_reg(8'h1c, {2'b00, sts[5:3], 1'b0, sts[2], sts[0] & (!sts[4] | sts[1])});
        end
        // Status is read-only: the write is dropped, all sources still high
        wr_reg(8'h1c, 8'h00);
        rd_reg(8'h1c, 8'h3b);
        $display("done status");
    endtask

    task t_pin();
        logic [3:0] cfg[6] = '{4'h0, 4'h1, 4'h9, 4'h2, 4'h3, 4'hf};
        logic       eoe[6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        logic       eout[6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
        for (int i = 0; i < 6; i++)
        begin
            wr_reg(8'h1d, {4'h5, cfg[i]});
            @(negedge clk);
            chk(poe, eoe[i]);
            if (!eoe[i])
                chk(po, eout[i]);
            rd_reg(8'h1d, {`CCSP_REVISION_VALUE, cfg[i]});
        end
        wr_reg(8'h1e, 8'h00);
        rd_reg(8'h1d, {`CCSP_REVISION_VALUE, 4'hf});
        pin = 1;
        repeat (6) @(negedge clk);
        chk(smp, 1'b1);
        sel = 1;
        wr_reg(8'h1d, 8'h09);
        @(negedge clk);
        chk({soe, so, poe}, 3'b011);
        // Opposite levels on the two pads show which one is sampled
        pin = 0;
        pin2 = 1;
        repeat (6) @(negedge clk);
        chk(smp, 1'b1);
        sel = 0;
        $display("done pin");
    endtask

    task t_freq();
        wr_reg(8'h1b, 8'h04);
        repeat (4) @(negedge clk);
        pix_edges(5);
        wait_idle();
        // Four periods from the write, of which 24 cycles pass before the wait
        chk(n, 4 * `CCSP_OSC_CYCLES - 24);
        rd_reg(8'h1b, 8'h05);
        wr_reg(8'h1b, 8'h60);
        pix_edges(300);
        wait_idle();
        rd_reg(8'h1b, 8'hff);
        wr_reg(8'h1b, 8'h60);
        pix_edges(10);
        wr_reg(8'h1b, 8'h01);
        wait_idle();
        chk(n, `CCSP_OSC_CYCLES);
        rd_reg(8'h1b, 8'h00);
        wr_reg(8'h1b, 8'h00);
        chk(busy, 1'b0);
        $display("done freq");
    endtask

    task close_out();
        $display("checks=%0d mismatches=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        repeat (10) @(negedge clk);
        rstn = 1;
        t_reset();
        t_status();
        t_pin();
        t_freq();
        close_out();
    end
endmodule // ccsp_regs_tb

`default_nettype wire
